// file: hw/epg_pod_gating.sv
// emulator pod: mode gating, trace flags, watchdog control and pod registers
//
// Functional notes
// - monitor flag high in monitor, low emulating
// - condition A drives trace flip flag low
// - condition B drives trace flip flag high
// - both A and B: B wins, high
// - a-then-b flag high with flip flag; latches after high-low-high
// - nonmaskable irq held high in monitor
// - ungated setting: bus clock always forwarded
// - gated setting: bus clock only when emulating
// - gated break gives one short final pulse
// - strobe reaches target only with strap fitted
// - qualifiers trace; first also feeds breakpoint
// - each probe bank captures eight signals
// - watchdog enabled on expanded-mode start
// - invoke or monitor chip reset disables watchdog
// - chip reset while emulating re-enables watchdog
// - watchdog keeps running after break
// - one-time config register: single write only
// - port init write never relocates ports
// - boot rom copy covers bf00 to bfff
// - port d bits six, seven output only
// - mode-a select bit reads one, fixed
`timescale 1ns/1ps
`default_nettype none
module epg_pod_gating
	import epg_pkg::*;
#(
	parameter int PROBE_W = EPG_PROBE_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire epg_bus_s bus_in,
	output logic [EPG_DATA_W-1:0] rdata,
	input wire epg_trig_s trig,
	input wire logic brk_req,
	input wire logic bus_phase_clk_in,
	input wire logic nonmaskable_irq_in,
	input wire logic load_instruction_strobe,
	input wire logic ext_qualifier_zero,
	input wire logic ext_qualifier_one,
	input wire logic [PROBE_W-1:0] trace_probe_bank_zero,
	input wire logic [PROBE_W-1:0] trace_probe_bank_one,
	input wire logic mcu_reset_in,
	output logic monitor_mode_flag,
	output logic trace_flip_flag,
	output logic trace_a_then_b_flag,
	output logic nonmaskable_irq_line,
	output logic bus_phase_clk_out,
	output logic mode_a_strap,
	output logic load_strobe_oe,
	output logic brk_qualifier,
	output logic [1:0] trace_qual,
	output logic [PROBE_W-1:0] trace_trace_probe_bank_zero_q,
	output logic [PROBE_W-1:0] trace_trace_probe_bank_one_q,
	output logic operating_watchdog,
	output logic [1:0] port_d_hi_out,
	output logic [1:0] port_d_hi_oe,
	output logic boot_rom_hit
);
	typedef enum logic [1:0] {
		EPG_FLAG_IDLE,
		EPG_FLAG_HI1,
		EPG_FLAG_LO,
		EPG_FLAG_DONE
	} epg_atb_e;

	logic [EPG_DATA_W-1:0] ctrl_r, ctrl_nxt;
	logic [EPG_DATA_W-1:0] once_cfg_r, once_cfg_nxt;
	logic once_done_r, once_done_nxt;
	logic [EPG_DATA_W-1:0] port_b_r, port_b_nxt;
	logic [EPG_DATA_W-1:0] port_c_r, port_c_nxt;
	logic [EPG_DATA_W-1:0] port_d_hi_r, port_d_hi_nxt;
	logic [EPG_DATA_W-1:0] prio_r, prio_nxt;
	logic [EPG_DATA_W-1:0] rdata_r, rdata_nxt;
	logic emul_r, emul_nxt;
	logic last_pulse_r, last_pulse_nxt;
	logic flip_r, flip_nxt;
	epg_atb_e atb_r, atb_nxt;
	logic wdog_r, wdog_nxt;
	logic mrst_d_r;
	logic strap_r;
	logic [1:0] qual_r;
	logic brkq_r;
	logic [PROBE_W-1:0] p0_r, p1_r;
	logic boot_r;
	logic clk_out_r, irq_out_r, strobe_oe_r;
	logic strap_nxt, strobe_oe_nxt, brkq_nxt, boot_nxt, clk_out_nxt, irq_out_nxt;
	logic [1:0] qual_nxt;
	logic [PROBE_W-1:0] p0_nxt, p1_nxt;
	logic mon_r, mon_nxt;
	logic atb_out_r, atb_out_nxt;
	logic [1:0] pd_oe_r, pd_oe_nxt;
	logic wr_ctrl;

	assign wr_ctrl = bus_in.wr && bus_in.addr == EPG_OFS_CTRL;

	// register writes and control
	always_comb begin
		ctrl_nxt = ctrl_r;
		once_cfg_nxt = once_cfg_r;
		once_done_nxt = once_done_r;
		port_b_nxt = port_b_r;
		port_c_nxt = port_c_r;
		port_d_hi_nxt = port_d_hi_r;
		prio_nxt = prio_r;
		if (bus_in.wr) begin
			case (bus_in.addr)
				EPG_OFS_CTRL: ctrl_nxt = bus_in.wdata;
				EPG_OFS_ONCE_CFG: begin
					if (!once_done_r) begin
						once_cfg_nxt = bus_in.wdata;
						once_done_nxt = 1'b1;
					end
				end
				EPG_OFS_PORT_INIT: ;
				EPG_OFS_PORT_B: port_b_nxt = bus_in.wdata;
				EPG_OFS_PORT_C: port_c_nxt = bus_in.wdata;
				EPG_OFS_PORT_D_HI: port_d_hi_nxt = bus_in.wdata & EPG_PORT_D_HI_MASK;
				EPG_OFS_PRIO: begin
					prio_nxt = bus_in.wdata;
					prio_nxt[EPG_PRIO_MODE_A_BIT] = 1'b1;
				end
				default: ;
			endcase
		end
		// one-shot command bits self-clear
		if (!wr_ctrl) begin
			ctrl_nxt[EPG_CTRL_ARM] = 1'b0;
			ctrl_nxt[EPG_CTRL_INVOKE] = 1'b0;
			ctrl_nxt[EPG_CTRL_CHIPRST] = 1'b0;
		end
	end

	// mode bit: emulation runs while run set, break ends it
	always_comb begin
		emul_nxt = ctrl_r[EPG_CTRL_RUN] && !brk_req;
		if (emul_r && brk_req) begin
			emul_nxt = 1'b0;
		end
		// one short pulse as gated emulation ends on a break
		last_pulse_nxt = emul_r && brk_req && ctrl_r[EPG_CTRL_GATED];
	end

	// trace flip flag and a-then-b latch
	always_comb begin
		flip_nxt = flip_r;
		if (trig.cond_b) begin
			flip_nxt = 1'b1;
		end else if (trig.cond_a) begin
			flip_nxt = 1'b0;
		end
		atb_nxt = atb_r;
		case (atb_r)
			EPG_FLAG_IDLE: if (flip_r) atb_nxt = EPG_FLAG_HI1;
			EPG_FLAG_HI1: if (!flip_r) atb_nxt = EPG_FLAG_LO;
			EPG_FLAG_LO: if (flip_r) atb_nxt = EPG_FLAG_DONE;
			EPG_FLAG_DONE: atb_nxt = EPG_FLAG_DONE;
			default: atb_nxt = EPG_FLAG_IDLE;
		endcase
		if (ctrl_r[EPG_CTRL_ARM]) begin
			atb_nxt = EPG_FLAG_IDLE;
		end
	end

	// watchdog enable
	always_comb begin
		wdog_nxt = wdog_r;
		if (ctrl_r[EPG_CTRL_INVOKE]) begin
			wdog_nxt = 1'b0;
		end
		if (ctrl_r[EPG_CTRL_CHIPRST] && !emul_r) begin
			wdog_nxt = 1'b0;
		end
		if (mcu_reset_in && !mrst_d_r && emul_r) begin
			wdog_nxt = 1'b1;
		end
		// a break leaves the watchdog untouched
	end

	// read mux
	always_comb begin
		rdata_nxt = '0;
		if (bus_in.rd) begin
			case (bus_in.addr)
				EPG_OFS_CTRL: rdata_nxt = ctrl_r;
				EPG_OFS_STATUS: begin
					rdata_nxt[EPG_ST_MON] = !emul_r;
					rdata_nxt[EPG_ST_FLIP] = flip_r;
					rdata_nxt[EPG_ST_ATB] = atb_r == EPG_FLAG_DONE;
					rdata_nxt[EPG_ST_WDOG] = wdog_r;
					rdata_nxt[EPG_ST_CFGDONE] = once_done_r;
				end
				EPG_OFS_ONCE_CFG: rdata_nxt = once_cfg_r;
				EPG_OFS_PORT_B: rdata_nxt = port_b_r;
				EPG_OFS_PORT_C: rdata_nxt = port_c_r;
				EPG_OFS_PORT_D_HI: rdata_nxt = port_d_hi_r;
				EPG_OFS_PRIO: rdata_nxt = prio_r;
				EPG_OFS_TRACE_PROBE_BANK_ZERO: rdata_nxt = EPG_DATA_W'(p0_r);
				EPG_OFS_TRACE_PROBE_BANK_ONE: rdata_nxt = EPG_DATA_W'(p1_r);
				EPG_OFS_QUAL: rdata_nxt = {6'h00, qual_r};
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_r <= EPG_CTRL_RST;
			once_cfg_r <= 8'h00;
			once_done_r <= 1'b0;
			port_b_r <= 8'h00;
			port_c_r <= 8'h00;
			port_d_hi_r <= 8'h00;
			prio_r <= EPG_PRIO_RST;
			rdata_r <= 8'h00;
			emul_r <= 1'b0;
			last_pulse_r <= 1'b0;
			flip_r <= 1'b0;
			atb_r <= EPG_FLAG_IDLE;
			wdog_r <= 1'b1;
			mrst_d_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			once_cfg_r <= once_cfg_nxt;
			once_done_r <= once_done_nxt;
			port_b_r <= port_b_nxt;
			port_c_r <= port_c_nxt;
			port_d_hi_r <= port_d_hi_nxt;
			prio_r <= prio_nxt;
			rdata_r <= rdata_nxt;
			emul_r <= emul_nxt;
			last_pulse_r <= last_pulse_nxt;
			flip_r <= flip_nxt;
			atb_r <= atb_nxt;
			wdog_r <= wdog_nxt;
			mrst_d_r <= mcu_reset_in;
		end
	end

	// pin stage next values
	always_comb begin
		strap_nxt = load_instruction_strobe;
		strobe_oe_nxt = ctrl_r[EPG_CTRL_STRAP];
		qual_nxt = {ext_qualifier_one, ext_qualifier_zero};
		brkq_nxt = ext_qualifier_zero;
		p0_nxt = trace_probe_bank_zero;
		p1_nxt = trace_probe_bank_one;
		boot_nxt = bus_in.addr >= EPG_BOOT_LO && bus_in.addr <= EPG_BOOT_HI;
		if (!ctrl_r[EPG_CTRL_GATED]) begin
			clk_out_nxt = bus_phase_clk_in;
		end else begin
			clk_out_nxt = bus_phase_clk_in && (emul_r || last_pulse_r);
		end
		irq_out_nxt = nonmaskable_irq_in || !emul_r;
		// flag moves on the same edge as both gates
		mon_nxt = !emul_r;
		atb_out_nxt = (atb_nxt == EPG_FLAG_DONE) || flip_nxt;
		pd_oe_nxt = 2'b11;
	end

	// pin stage: all outputs registered
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			strap_r <= 1'b1;
			qual_r <= 2'b00;
			brkq_r <= 1'b0;
			p0_r <= '0;
			p1_r <= '0;
			boot_r <= 1'b0;
			clk_out_r <= 1'b0;
			irq_out_r <= 1'b1;
			strobe_oe_r <= 1'b0;
			mon_r <= 1'b1;
			atb_out_r <= 1'b0;
			pd_oe_r <= 2'b11;
		end else begin
			strap_r <= strap_nxt;
			strobe_oe_r <= strobe_oe_nxt;
			qual_r <= qual_nxt;
			brkq_r <= brkq_nxt;
			p0_r <= p0_nxt;
			p1_r <= p1_nxt;
			boot_r <= boot_nxt;
			clk_out_r <= clk_out_nxt;
			irq_out_r <= irq_out_nxt;
			mon_r <= mon_nxt;
			atb_out_r <= atb_out_nxt;
			pd_oe_r <= pd_oe_nxt;
		end
	end

	assign rdata = rdata_r;
	assign monitor_mode_flag = mon_r;
	assign trace_flip_flag = flip_r;
	assign trace_a_then_b_flag = atb_out_r;
	assign nonmaskable_irq_line = irq_out_r;
	assign bus_phase_clk_out = clk_out_r;
	assign mode_a_strap = strap_r;
	assign load_strobe_oe = strobe_oe_r;
	assign brk_qualifier = brkq_r;
	assign trace_qual = qual_r;
	assign trace_trace_probe_bank_zero_q = p0_r;
	assign trace_trace_probe_bank_one_q = p1_r;
	assign operating_watchdog = wdog_r;
	assign port_d_hi_out = port_d_hi_r[7:6];
	assign port_d_hi_oe = pd_oe_r;
	assign boot_rom_hit = boot_r;
endmodule
`default_nettype wire

// file: hw/epg_pkg.sv
// package for emulator pod mode gating: constants and carriers
package epg_pkg;
	localparam int EPG_PROBE_W = 8;
	localparam int EPG_ADDR_W = 16;
	localparam int EPG_DATA_W = 8;
	// register offsets of the pod control block
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_CTRL = 16'h0000;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_STATUS = 16'h0001;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_ONCE_CFG = 16'h0002;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_PORT_INIT = 16'h0003;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_PORT_B = 16'h0004;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_PORT_C = 16'h0005;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_PORT_D_HI = 16'h0006;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_PRIO = 16'h0007;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_TRACE_PROBE_BANK_ZERO = 16'h0008;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_TRACE_PROBE_BANK_ONE = 16'h0009;
	localparam logic [EPG_ADDR_W-1:0] EPG_OFS_QUAL = 16'h000a;
	// ctrl fields
	localparam int EPG_CTRL_RUN = 0;
	localparam int EPG_CTRL_GATED = 1;
	localparam int EPG_CTRL_STRAP = 2;
	localparam int EPG_CTRL_ARM = 3;
	localparam int EPG_CTRL_INVOKE = 4;
	localparam int EPG_CTRL_CHIPRST = 5;
	// ctrl: clear run, gated clock on, strap open
	localparam logic [EPG_DATA_W-1:0] EPG_CTRL_RST = 8'h02;
	// status fields
	localparam int EPG_ST_MON = 0;
	localparam int EPG_ST_FLIP = 1;
	localparam int EPG_ST_ATB = 2;
	localparam int EPG_ST_WDOG = 3;
	localparam int EPG_ST_CFGDONE = 4;
	// priority mode register: mode-a select bit stuck at one
	localparam int EPG_PRIO_MODE_A_BIT = 5;
	localparam logic [EPG_DATA_W-1:0] EPG_PRIO_RST = 8'h20;
	// boot rom window
	localparam logic [EPG_ADDR_W-1:0] EPG_BOOT_LO = 16'hbf00;
	localparam logic [EPG_ADDR_W-1:0] EPG_BOOT_HI = 16'hbfff;
	localparam logic [EPG_DATA_W-1:0] EPG_PORT_D_HI_MASK = 8'hc0;

	typedef struct packed {
		logic cond_a;
		logic cond_b;
	} epg_trig_s;

	typedef struct packed {
		logic [EPG_ADDR_W-1:0] addr;
		logic [EPG_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} epg_bus_s;
endpackage

// file: verif/epg_pod_gating_checker.sv
// assertion checker for the pod gating block
`timescale 1ns/1ps
`default_nettype none
module epg_pod_gating_checker
	import epg_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire epg_bus_s bus_in,
	input wire epg_trig_s trig,
	input wire logic bus_phase_clk_in,
	input wire logic ext_qualifier_zero,
	input wire logic ext_qualifier_one,
	input wire logic monitor_mode_flag,
	input wire logic trace_flip_flag,
	input wire logic trace_a_then_b_flag,
	input wire logic nonmaskable_irq_line,
	input wire logic bus_phase_clk_out,
	input wire logic brk_qualifier,
	input wire logic [1:0] trace_qual,
	input wire logic [1:0] port_d_hi_oe,
	input wire logic boot_rom_hit
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_irq;
		monitor_mode_flag && $past(monitor_mode_flag) |-> nonmaskable_irq_line;
	endproperty
	a_irq: assert property (p_irq) else $error("irq line low in monitor");
	property p_clk;
		!monitor_mode_flag && !$past(monitor_mode_flag) |-> bus_phase_clk_out == $past(bus_phase_clk_in);
	endproperty
	a_clk: assert property (p_clk) else $error("phase clock not forwarded");
	property p_flipb;
		trig.cond_b |=> trace_flip_flag;
	endproperty
	a_flipb: assert property (p_flipb) else $error("flip flag not high");
	property p_flipa;
		trig.cond_a && !trig.cond_b |=> !trace_flip_flag;
	endproperty
	a_flipa: assert property (p_flipa) else $error("flip flag not low");
	property p_atb;
		trace_flip_flag |-> trace_a_then_b_flag;
	endproperty
	a_atb: assert property (p_atb) else $error("a then b flag low");
	property p_qual;
		1'b1 |=> brk_qualifier == $past(ext_qualifier_zero)
			&& trace_qual == {$past(ext_qualifier_one), $past(ext_qualifier_zero)};
	endproperty
	a_qual: assert property (p_qual) else $error("qualifier mismatch");
	property p_pdoe;
		port_d_hi_oe == 2'h3;
	endproperty
	a_pdoe: assert property (p_pdoe) else $error("port d bit not output");
	property p_boot;
		bus_in.rd || bus_in.wr |=> boot_rom_hit
			== ($past(bus_in.addr) >= EPG_BOOT_LO && $past(bus_in.addr) <= EPG_BOOT_HI);
	endproperty
	a_boot: assert property (p_boot) else $error("boot window hit wrong");
endmodule
bind epg_pod_gating epg_pod_gating_checker i_chk (.core_clk(core_clk), .nrst(nrst),
	.bus_in(bus_in), .trig(trig), .bus_phase_clk_in(bus_phase_clk_in),
	.ext_qualifier_zero(ext_qualifier_zero), .ext_qualifier_one(ext_qualifier_one),
	.monitor_mode_flag(monitor_mode_flag), .trace_flip_flag(trace_flip_flag),
	.trace_a_then_b_flag(trace_a_then_b_flag), .nonmaskable_irq_line(nonmaskable_irq_line),
	.bus_phase_clk_out(bus_phase_clk_out), .brk_qualifier(brk_qualifier),
	.trace_qual(trace_qual), .port_d_hi_oe(port_d_hi_oe), .boot_rom_hit(boot_rom_hit));
`default_nettype wire

// file: verif/epg_target_model.sv
// target board model: phase clock and irq source
`timescale 1ns/1ps
`default_nettype none
module epg_target_model (
	input wire logic core_clk,
	input wire logic irq_req,
	output logic bus_phase_clk_in,
	output logic nonmaskable_irq_in
);
	initial bus_phase_clk_in = 1'b0;
	initial nonmaskable_irq_in = 1'b1;
	// free-running phase clock, active-low irq; strobe line never driven
	always @(posedge core_clk) begin
		bus_phase_clk_in <= ~bus_phase_clk_in;
		nonmaskable_irq_in <= ~irq_req;
	end
endmodule
`default_nettype wire

// file: verif/emulator_pod_mode_gating_tb_top.sv
// self-checking bench for the pod gating block
`timescale 1ns/1ps
`default_nettype none
module emulator_pod_mode_gating_tb_top
	import epg_pkg::*;
;
	logic core_clk = 1'b0;
	logic nrst, brk_req, mcu_reset_in, strobe, q0, q1, irq_req, pclk, pirq;
	logic mon, flip, atb, irq, clk_o, oe, wdog, hit;
	logic [7:0] p0, p1, rdata, p0q, p1q;
	epg_bus_s bus_in;
	epg_trig_s trig;
	int error_cnt = 0;
	int num_checks = 0;
	always #20 core_clk = ~core_clk;
	epg_pod_gating i_dut (.core_clk(core_clk), .nrst(nrst), .bus_in(bus_in), .rdata(rdata),
		.trig(trig), .brk_req(brk_req), .bus_phase_clk_in(pclk), .nonmaskable_irq_in(pirq),
		.load_instruction_strobe(strobe), .ext_qualifier_zero(q0), .ext_qualifier_one(q1),
		.trace_probe_bank_zero(p0), .trace_probe_bank_one(p1), .mcu_reset_in(mcu_reset_in),
		.monitor_mode_flag(mon), .trace_flip_flag(flip), .trace_a_then_b_flag(atb),
		.nonmaskable_irq_line(irq), .bus_phase_clk_out(clk_o), .mode_a_strap(),
		.load_strobe_oe(oe), .brk_qualifier(), .trace_qual(), .trace_trace_probe_bank_zero_q(p0q),
		.trace_trace_probe_bank_one_q(p1q), .operating_watchdog(wdog), .port_d_hi_out(),
		.port_d_hi_oe(), .boot_rom_hit(hit));
	epg_target_model i_tgt (.core_clk(core_clk), .irq_req(irq_req),
		.bus_phase_clk_in(pclk), .nonmaskable_irq_in(pirq));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_in.addr <= a;
		bus_in.wdata <= d;
		bus_in.wr <= 1'b1;
		@(posedge core_clk);
		bus_in.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		bus_in.addr <= a;
		bus_in.rd <= 1'b1;
		@(posedge core_clk);
		bus_in.rd <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask
	task automatic st();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic ck(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		repeat (8) begin
			@(posedge core_clk);
			#1 n = n + clk_o;
		end
		chk("clk highs", exp, n);
	endtask
	task automatic tg(input logic a, input logic b, input logic [7:0] ef, input logic [7:0] ea);
		@(posedge core_clk) trig <= '{cond_a: a, cond_b: b};
		st();
		chk("flip", ef, flip);
		chk("atb", ea, atb);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		nrst = 1'b0;
		bus_in = '0;
		trig = '0;
		{brk_req, mcu_reset_in, strobe, q0, q1, irq_req} = '0;
		p0 = 8'h5a;
		p1 = 8'ha5;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(EPG_OFS_STATUS, 8'h09, "status");
		rd(EPG_OFS_CTRL, EPG_CTRL_RST, "ctrl");
		wr(EPG_OFS_PRIO, 8'h00);
		rd(EPG_OFS_PRIO, EPG_PRIO_RST, "prio");
		wr(EPG_OFS_ONCE_CFG, 8'h5a);
		wr(EPG_OFS_ONCE_CFG, 8'ha5);
		rd(EPG_OFS_ONCE_CFG, 8'h5a, "cfg");
		wr(EPG_OFS_PORT_B, 8'h3c);
		wr(EPG_OFS_PORT_INIT, 8'hf0);
		rd(EPG_OFS_PORT_B, 8'h3c, "port b");
		wr(EPG_OFS_PORT_D_HI, 8'hff);
		rd(EPG_OFS_PORT_D_HI, EPG_PORT_D_HI_MASK, "port d");
		rd(EPG_OFS_TRACE_PROBE_BANK_ZERO, 8'h5a, "trace_probe_bank_zero");
		rd(EPG_OFS_TRACE_PROBE_BANK_ONE, 8'ha5, "trace_probe_bank_one");
		q0 <= 1'b1;
		rd(16'hbf00, 8'h00, "unmapped");
		chk("boot", 8'h01, hit);
		rd(16'hc000, 8'h00, "unmapped");
		chk("boot", 8'h00, hit);
		ck(8'h00);
		wr(EPG_OFS_CTRL, 8'h04);
		st();
		chk("strobe oe", 8'h01, oe);
		ck(8'h04);
		wr(EPG_OFS_CTRL, 8'h00);
		st();
		chk("strobe oe", 8'h00, oe);
		irq_req <= 1'b1;
		wr(EPG_OFS_CTRL, 8'h03);
		st();
		chk("mon", 8'h00, mon);
		chk("irq", 8'h00, irq);
		ck(8'h04);
		rd(EPG_OFS_STATUS, 8'h18, "status");
		wr(EPG_OFS_CTRL, 8'h13);
		st();
		chk("wdog", 8'h00, wdog);
		@(posedge core_clk) mcu_reset_in <= 1'b1;
		st();
		chk("wdog", 8'h01, wdog);
		@(posedge core_clk) mcu_reset_in <= 1'b0;
		@(posedge core_clk) brk_req <= 1'b1;
		st();
		chk("mon", 8'h01, mon);
		chk("irq", 8'h01, irq);
		chk("wdog", 8'h01, wdog);
		ck(8'h00);
		wr(EPG_OFS_CTRL, 8'h22);
		st();
		chk("wdog", 8'h00, wdog);
		@(posedge core_clk) brk_req <= 1'b0;
		tg(1'b0, 1'b1, 8'h01, 8'h01);
		tg(1'b1, 1'b1, 8'h01, 8'h01);
		tg(1'b1, 1'b0, 8'h00, 8'h00);
		tg(1'b0, 1'b1, 8'h01, 8'h01);
		tg(1'b1, 1'b0, 8'h00, 8'h01);
		wr(EPG_OFS_CTRL, 8'h0a);
		st();
		chk("atb", 8'h00, atb);
		tg(1'b0, 1'b1, 8'h01, 8'h01);
		print_verdict();
	end
endmodule
`default_nettype wire
